/* wdc_pkg.sv */
// Purpose: Constants and types for the watchdog channel 0 counter
// Assumes: 10 MHz system clock, one clock domain
// Notes:   Offsets, keys and pulse length are local choices

package wdc_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int         ADDR_W        = 4;
   localparam int         DATA_W        = 8;
   localparam int         WDATA_W       = 16;
   localparam logic [3:0] ADDR_COUNT    = 4'h0;
   localparam logic [3:0] ADDR_CTRL     = 4'h1;
   localparam logic [3:0] ADDR_RSTCFG   = 4'h2;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
   localparam logic [3:0] ADDR_IRQ_EN   = 4'h4;
   localparam logic [3:0] ADDR_IRQ_CLR  = 4'h5;

   // Keys for the protected write method (upper write-data byte)
   localparam logic [7:0] KEY_COUNT     = 8'h5a;
   localparam logic [7:0] KEY_CTRL      = 8'ha5;

   // ---------------------------------------------------------------
   // Control/status field layout
   // ---------------------------------------------------------------
   localparam int         OVF_BIT       = 7;
   localparam int         MODE_BIT      = 6;
   localparam int         ENABLE_BIT    = 5;
   localparam int         RSV_HI_BIT    = 4;
   localparam int         RSV_LO_BIT    = 3;
   localparam int         CKS_MSB       = 2;
   localparam int         RSTSEL_BIT    = 0;

   // ---------------------------------------------------------------
   // Reset values and count limit
   // ---------------------------------------------------------------
   localparam logic [7:0] COUNT_RESET   = 8'h00;
   localparam logic [7:0] COUNT_MAX     = 8'hff;
   localparam logic [2:0] CKS_RESET     = 3'h0;
   localparam logic       RSTSEL_RESET  = 1'b0;
   localparam logic [2:0] EVT_RESET     = 3'h0;

   // ---------------------------------------------------------------
   // Prescaler taps
   // ---------------------------------------------------------------
   localparam int          PRESC_W       = 17;
   localparam logic [16:0] PRESC_RESET   = 17'h0_0000;
   localparam logic [16:0] DIV2_MASK     = 17'h0_0001;
   localparam logic [16:0] DIV64_MASK    = 17'h0_003f;
   localparam logic [16:0] DIV128_MASK   = 17'h0_007f;
   localparam logic [16:0] DIV512_MASK   = 17'h0_01ff;
   localparam logic [16:0] DIV2048_MASK  = 17'h0_07ff;
   localparam logic [16:0] DIV8192_MASK  = 17'h0_1fff;
   localparam logic [16:0] DIV32768_MASK = 17'h0_7fff;
   localparam logic [16:0] DIV131072_MASK = 17'h1_ffff;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS    = 100;
   localparam int RESET_PULSE_NS     = 500;
   localparam int RESET_PULSE_CYCLES =
      (RESET_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } wdc_bus_req_t;

   typedef struct packed {
      logic       mode_watchdog;
      logic       count_enable;
      logic [2:0] clock_select;
   } wdc_ctrl_t;

   typedef struct packed {
      logic write_rejected;
      logic watchdog_ovf;
      logic interval_ovf;
   } wdc_events_t;

   typedef enum logic [1:0] {
      WDC_RUN   = 2'b01,
      WDC_RESET = 2'b10
   } wdc_state_t;

endpackage

/* wdc_channel0.sv */
// Purpose: Watchdog / interval timer channel 0 with register port
// Assumes: Bus master never reads and writes in the same cycle
// Notes:   One clock; keyed writes guard count and control

`timescale 1ns/1ps

module wdc_channel0 (
   input  wire logic                  clock,
   input  wire logic                  reset_n,
   input  wire wdc_pkg::wdc_bus_req_t bus_req,
   output logic [7:0]                 rdata,
   output logic                       irq,
   output logic                       interval_overflow_irq,
   output logic                       nmi_request,
   output logic                       internal_reset_out
);
   import wdc_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic                rst_meta_reg;
   logic                rst_n_sync;
   logic [PRESC_W-1:0]  presc_reg;
   logic [7:0]          count_reg;
   logic [7:0]          count_next;
   wdc_ctrl_t           ctrl_reg;
   logic                ovf_reg;
   logic                ovf_next;
   logic                ovf_armed_reg;
   logic                reset_select_reg;
   wdc_state_t          state_reg;
   logic [3:0]          pulse_cnt_reg;
   wdc_events_t         irq_stat_reg;
   wdc_events_t         irq_en_reg;
   wdc_events_t         evt_now;
   logic [7:0]          rdata_reg;
   logic                interval_irq_reg;
   logic                nmi_reg;
   logic                tick;
   logic                in_run;
   logic                count_wr_ok;
   logic                ctrl_wr_ok;
   logic                rstcfg_wr_ok;
   logic                bad_key_wr;
   logic                overflow_event;
   logic                ctrl_read;

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   function automatic logic tick_for(input logic [2:0]         sel,
                                     input logic [PRESC_W-1:0] p);
      logic [PRESC_W-1:0] mask;
      mask = DIV2_MASK;
      case (sel)
         3'b000: mask = DIV2_MASK;
         3'b001: mask = DIV64_MASK;
         3'b010: mask = DIV128_MASK;
         3'b011: mask = DIV512_MASK;
         3'b100: mask = DIV2048_MASK;
         3'b101: mask = DIV8192_MASK;
         3'b110: mask = DIV32768_MASK;
         default: mask = DIV131072_MASK;
      endcase
      tick_for = ((p & mask) == mask);
   endfunction

   function automatic logic key_write(input wdc_bus_req_t r,
                                      input logic [3:0]   a,
                                      input logic [7:0]   k);
      key_write = r.wr && (r.addr == a) && (r.wdata[15:8] == k);
   endfunction

   function automatic logic [7:0] ctrl_byte(input logic      ovf,
                                            input wdc_ctrl_t c);
      logic [7:0] b;
      b                 = 8'h00;
      b[OVF_BIT]        = ovf;
      b[MODE_BIT]       = c.mode_watchdog;
      b[ENABLE_BIT]     = c.count_enable;
      b[RSV_HI_BIT]     = 1'b1;
      b[RSV_LO_BIT]     = 1'b1;
      b[CKS_MSB:0]      = c.clock_select;
      ctrl_byte         = b;
   endfunction

   // ---------------------------------------------------------------
   // Reset synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_n_sync   <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_sync   <= rst_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // Access decode
   // ---------------------------------------------------------------
   assign in_run       = (state_reg == WDC_RUN);
   assign count_wr_ok  = key_write(bus_req, ADDR_COUNT, KEY_COUNT);
   assign ctrl_wr_ok   = key_write(bus_req, ADDR_CTRL, KEY_CTRL);
   assign rstcfg_wr_ok = key_write(bus_req, ADDR_RSTCFG, KEY_CTRL);
   assign bad_key_wr   = bus_req.wr && !count_wr_ok && !ctrl_wr_ok &&
                         !rstcfg_wr_ok &&
                         ((bus_req.addr == ADDR_COUNT) ||
                          (bus_req.addr == ADDR_CTRL) ||
                          (bus_req.addr == ADDR_RSTCFG));
   assign ctrl_read    = bus_req.rd && (bus_req.addr == ADDR_CTRL);

   // ---------------------------------------------------------------
   // Prescaler
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         presc_reg <= PRESC_RESET;
      end else begin
         presc_reg <= presc_reg + 17'h0_0001;
      end
   end

   assign tick = tick_for(ctrl_reg.clock_select, presc_reg);

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   assign overflow_event = in_run && ctrl_reg.count_enable && tick &&
                           !count_wr_ok && (count_reg == COUNT_MAX);

   always_comb begin
      count_next = count_reg;
      if (!in_run || !ctrl_reg.count_enable) begin
         count_next = COUNT_RESET;
      end else if (count_wr_ok) begin
         count_next = bus_req.wdata[7:0];
      end else if (tick) begin
         count_next = count_reg + 8'h01;
      end
   end

   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         count_reg <= COUNT_RESET;
      end else begin
         count_reg <= count_next;
      end
   end

   // ---------------------------------------------------------------
   // Control fields
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         ctrl_reg.mode_watchdog <= 1'b0;
         ctrl_reg.count_enable  <= 1'b0;
         ctrl_reg.clock_select  <= CKS_RESET;
      end else if (!in_run) begin
         ctrl_reg.mode_watchdog <= 1'b0;
         ctrl_reg.count_enable  <= 1'b0;
         ctrl_reg.clock_select  <= CKS_RESET;
      end else if (ctrl_wr_ok) begin
         ctrl_reg.mode_watchdog <= bus_req.wdata[MODE_BIT];
         ctrl_reg.count_enable  <= bus_req.wdata[ENABLE_BIT];
         ctrl_reg.clock_select  <= bus_req.wdata[CKS_MSB:0];
      end
   end

   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         reset_select_reg <= RSTSEL_RESET;
      end else if (rstcfg_wr_ok) begin
         reset_select_reg <= bus_req.wdata[RSTSEL_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Overflow flag
   // ---------------------------------------------------------------
   always_comb begin
      ovf_next = ovf_reg;
      if (!in_run) begin
         ovf_next = 1'b0;
      end else if (overflow_event) begin
         ovf_next = 1'b1;
      end else if (ctrl_wr_ok && ovf_armed_reg &&
                   !bus_req.wdata[OVF_BIT]) begin
         ovf_next = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         ovf_reg <= 1'b0;
      end else begin
         ovf_reg <= ovf_next;
      end
   end

   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         ovf_armed_reg <= 1'b0;
      end else if (ctrl_read && ovf_reg) begin
         ovf_armed_reg <= 1'b1;
      end else if (ctrl_wr_ok || !ovf_reg) begin
         ovf_armed_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Overflow actions
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         state_reg     <= WDC_RUN;
         pulse_cnt_reg <= 4'h0;
      end else begin
         case (state_reg)
            WDC_RUN: begin
               if (overflow_event && ctrl_reg.mode_watchdog &&
                   reset_select_reg) begin
                  state_reg     <= WDC_RESET;
                  pulse_cnt_reg <= 4'(RESET_PULSE_CYCLES - 1);
               end
            end
            WDC_RESET: begin
               if (pulse_cnt_reg == 4'h0) begin
                  state_reg <= WDC_RUN;
               end else begin
                  pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
               end
            end
            default: begin
               state_reg <= WDC_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         interval_irq_reg <= 1'b0;
         nmi_reg          <= 1'b0;
      end else begin
         interval_irq_reg <= overflow_event &&
                             !ctrl_reg.mode_watchdog;
         nmi_reg          <= overflow_event &&
                             ctrl_reg.mode_watchdog &&
                             !reset_select_reg;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt status, enable and clear
   // ---------------------------------------------------------------
   assign evt_now.write_rejected = bad_key_wr;
   assign evt_now.watchdog_ovf   = overflow_event &&
                                   ctrl_reg.mode_watchdog;
   assign evt_now.interval_ovf   = overflow_event &&
                                   !ctrl_reg.mode_watchdog;

   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         irq_stat_reg <= EVT_RESET;
      end else if (bus_req.wr && (bus_req.addr == ADDR_IRQ_CLR)) begin
         irq_stat_reg <= (irq_stat_reg & ~bus_req.wdata[2:0]) | evt_now;
      end else begin
         irq_stat_reg <= irq_stat_reg | evt_now;
      end
   end

   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         irq_en_reg <= EVT_RESET;
      end else if (bus_req.wr && (bus_req.addr == ADDR_IRQ_EN)) begin
         irq_en_reg <= bus_req.wdata[2:0];
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         rdata_reg <= 8'h00;
      end else if (!bus_req.rd) begin
         rdata_reg <= 8'h00;
      end else if (bus_req.addr == ADDR_COUNT) begin
         rdata_reg <= count_reg;
      end else if (bus_req.addr == ADDR_CTRL) begin
         rdata_reg <= ctrl_byte(ovf_reg, ctrl_reg);
      end else if (bus_req.addr == ADDR_RSTCFG) begin
         rdata_reg <= {7'h00, reset_select_reg};
      end else if (bus_req.addr == ADDR_IRQ_STAT) begin
         rdata_reg <= {5'h00, irq_stat_reg};
      end else if (bus_req.addr == ADDR_IRQ_EN) begin
         rdata_reg <= {5'h00, irq_en_reg};
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign rdata                 = rdata_reg;
   assign irq                   = |(irq_stat_reg & irq_en_reg);
   assign interval_overflow_irq = interval_irq_reg;
   assign nmi_request           = nmi_reg;
   assign internal_reset_out    = (state_reg == WDC_RESET);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_INTRESET_ZERO: assert property (
      @(posedge clock) disable iff (!rst_n_sync)
      (state_reg == WDC_RESET) |=> (count_reg == COUNT_RESET))
      else $error("Count not zero after internal reset");

   AST_HOLD_ZERO: assert property (
      @(posedge clock) disable iff (!rst_n_sync)
      !ctrl_reg.count_enable |=> (count_reg == COUNT_RESET))
      else $error("Count not held at zero while disabled");

   AST_ADVANCE: assert property (
      @(posedge clock) disable iff (!rst_n_sync)
      (in_run && ctrl_reg.count_enable && tick && !count_wr_ok)
      |=> (count_reg == 8'($past(count_reg) + 8'h01)))
      else $error("Count did not advance on tick");

   AST_OVF_SET: assert property (
      @(posedge clock) disable iff (!rst_n_sync)
      overflow_event |=> (ovf_reg && (count_reg == COUNT_RESET)))
      else $error("Overflow did not set flag");

   AST_NO_SW_SET: assert property (
      @(posedge clock) disable iff (!rst_n_sync)
      (!ovf_reg && !overflow_event) |=> !ovf_reg)
      else $error("Overflow flag set without overflow");

   AST_CLEAR_NEEDS_READ: assert property (
      @(posedge clock) disable iff (!rst_n_sync)
      (ovf_reg && !ovf_armed_reg && in_run) |=> ovf_reg)
      else $error("Overflow flag cleared without prior read");

   AST_REJECT_PLAIN: assert property (
      @(posedge clock) disable iff (!rst_n_sync)
      (in_run && bus_req.wr && (bus_req.addr == ADDR_CTRL) &&
       (bus_req.wdata[15:8] != KEY_CTRL))
      |=> (ctrl_reg == $past(ctrl_reg)))
      else $error("Plain write changed control register");

   AST_INTERVAL_IRQ: assert property (
      @(posedge clock) disable iff (!rst_n_sync)
      (overflow_event && !ctrl_reg.mode_watchdog)
      |=> interval_overflow_irq ##1 !interval_overflow_irq)
      else $error("Interval interrupt missing or stretched");

   AST_WDT_RESET: assert property (
      @(posedge clock) disable iff (!rst_n_sync)
      (overflow_event && ctrl_reg.mode_watchdog && reset_select_reg)
      |=> internal_reset_out ##1 (internal_reset_out && !ovf_reg))
      else $error("Watchdog overflow did not reset and clear flag");

   AST_RESERVED_ONES: assert property (
      @(posedge clock) disable iff (!rst_n_sync)
      ctrl_read |=> (rdata[RSV_HI_BIT:RSV_LO_BIT] == 2'b11))
      else $error("Reserved bits not read as one");

   AST_DIV2_TICK: assert property (
      @(posedge clock) disable iff (!rst_n_sync)
      ($past(rst_n_sync) && (ctrl_reg.clock_select == 3'b000) &&
       ($past(ctrl_reg.clock_select) == 3'b000))
      |-> (tick != $past(tick)))
      else $error("Divide-by-two tick not alternating");

   AST_DIV131072_TICK: assert property (
      @(posedge clock) disable iff (!rst_n_sync)
      ((ctrl_reg.clock_select == 3'b111) && tick)
      |-> (presc_reg == DIV131072_MASK))
      else $error("Slowest tick before prescaler wrap");

endmodule

/* wdc_channel0_tb.sv */
// Purpose: Self-checking bench for the watchdog channel 0 counter
// Assumes: Register port driven at rising edges, no random stimulus
// Notes:   Long prescaler codes partly covered by in-design assertions

`timescale 1ns/1ps

`define CHK(got, exp, msg) \
   begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
   $display("BAD %0t %s got %h", $time, msg, got); end end

module wdc_channel0_tb;
   import wdc_pkg::*;

   logic         clock;
   logic         reset_n;
   wdc_bus_req_t bus_req;
   logic [7:0]   rdata;
   logic         irq;
   logic         interval_overflow_irq;
   logic         nmi_request;
   logic         internal_reset_out;
   int           mismatches;
   int           total_checks;

   wdc_channel0 wdc_channel0_inst (
      .clock                 (clock),
      .reset_n               (reset_n),
      .bus_req               (bus_req),
      .rdata                 (rdata),
      .irq                   (irq),
      .interval_overflow_irq (interval_overflow_irq),
      .nmi_request           (nmi_request),
      .internal_reset_out    (internal_reset_out)
   );

   // ---------------------------------------------------------------
   // Clock, bus tasks, closing
   // ---------------------------------------------------------------
   initial clock = 1'b0;
   always #50 clock = ~clock;

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus_req.wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus_req.rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Waits up to n cycles for a pulse; returns 1 if seen
   task automatic wait_sig(input int sel, input int n, output logic hit);
      hit = 1'b0;
      for (int i = 0; i < n && !hit; i++) begin
         @(posedge clock);
         #1 hit = (sel == 0) ? interval_overflow_irq :
                  (sel == 1) ? nmi_request : internal_reset_out;
      end
   endtask

   task automatic summarize;
      if (mismatches == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset_and_protect;
      logic [7:0] d;
      rd(ADDR_COUNT, d);     `CHK(d, 8'h00, "count reset")
      rd(ADDR_CTRL, d);      `CHK(d, 8'h18, "ctrl reset")
      wr(ADDR_IRQ_EN, 16'h0007);
      wr(ADDR_CTRL, 16'h0060);
      rd(ADDR_CTRL, d);      `CHK(d, 8'h18, "plain write taken")
      rd(ADDR_IRQ_STAT, d);  `CHK(d, 8'h04, "reject status")
      `CHK(irq, 1'b1, "irq low")
      wr(ADDR_IRQ_CLR, 16'h0004);
      rd(4'h9, d);           `CHK(d, 8'h00, "unmapped read")
      `CHK(irq, 1'b0, "irq not cleared")
   endtask

   task automatic t_interval;
      logic [7:0] d;
      logic       hit;
      wr(ADDR_CTRL, 16'ha5_b8);
      rd(ADDR_CTRL, d);      `CHK(d, 8'h38, "ctrl write")
      wr(ADDR_COUNT, 16'h5a_fe);
      wait_sig(0, 20, hit);  `CHK(hit, 1'b1, "no interval irq")
      rd(ADDR_CTRL, d);      `CHK(d, 8'hb8, "flag not set")
      rd(ADDR_IRQ_STAT, d);  `CHK(d, 8'h01, "interval status")
      `CHK(irq, 1'b1, "irq level")
      wr(ADDR_CTRL, 16'ha5_b8);
      rd(ADDR_CTRL, d);      `CHK(d[7], 1'b1, "flag lost on w1")
      wr(ADDR_CTRL, 16'ha5_38);
      rd(ADDR_CTRL, d);      `CHK(d[7], 1'b0, "flag not cleared")
      wr(ADDR_IRQ_EN, 16'h0006);
      `CHK(irq, 1'b0, "irq masked")
      wr(ADDR_IRQ_CLR, 16'h0001);
      wr(ADDR_IRQ_EN, 16'h0007);
      `CHK(irq, 1'b0, "irq after clear")
   endtask

   task automatic t_rates;
      logic [2:0] code [4] = '{3'h0, 3'h1, 3'h6, 3'h7};
      int         span [4] = '{64, 128, 65536, 64};
      int         dv   [4] = '{2, 64, 32768, 131072};
      logic [7:0] a;
      logic [7:0] b;
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_CTRL, {8'ha5, 5'b00100, code[i]});
         rd(ADDR_COUNT, a);
         repeat (span[i] - 2) @(posedge clock);
         rd(ADDR_COUNT, b);
         `CHK(b - a, 8'(span[i] / dv[i]), "rate")
      end
      wr(ADDR_CTRL, 16'ha5_00);
      wr(ADDR_COUNT, 16'h5a_40);
      rd(ADDR_COUNT, a);     `CHK(a, 8'h00, "count not held")
   endtask

   task automatic t_watchdog;
      logic [7:0] d;
      logic       hit;
      int         n;
      wr(ADDR_CTRL, 16'ha5_60);
      wr(ADDR_COUNT, 16'h5a_fe);
      rd(ADDR_COUNT, d);     `CHK(d >= 8'hfe, 1'b1, "count write")
      wait_sig(1, 20, hit);  `CHK(hit, 1'b1, "no nmi")
      wr(ADDR_CTRL, 16'ha5_00);
      wr(ADDR_RSTCFG, 16'ha5_01);
      wr(ADDR_CTRL, 16'ha5_60);
      wr(ADDR_COUNT, 16'h5a_fe);
      wait_sig(2, 20, hit);  `CHK(hit, 1'b1, "no reset out")
      n = 0;
      while (internal_reset_out === 1'b1 && n < 20) begin
         @(posedge clock);
         #1 n++;
      end
      `CHK(n, RESET_PULSE_CYCLES, "reset length")
      rd(ADDR_CTRL, d);      `CHK(d, 8'h18, "flag survived")
      rd(ADDR_IRQ_STAT, d);  `CHK(d[1], 1'b1, "watchdog status")
   endtask

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      mismatches   = 0;
      total_checks = 0;
      reset_n      = 1'b0;
      bus_req      = '0;
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      repeat (3) @(posedge clock);
      t_reset_and_protect();
      t_interval();
      t_rates();
      t_watchdog();
      summarize();
   end

   initial begin
      #(80_000 * 100);
      mismatches++;
      summarize();
   end

endmodule
